// *** rtl/rnpc_pkg.sv ***
// package: register map, field positions, reset values and carrier types
package rnpc_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] RNPC_ADDR_W            = 8'h08;
	localparam logic [7:0] RNPC_OFS_RESET_CAUSE   = 8'h00;
	localparam logic [7:0] RNPC_OFS_SW_RESET      = 8'h04;
	localparam logic [7:0] RNPC_OFS_NMI_CONTROL   = 8'h08;
	localparam logic [7:0] RNPC_OFS_POWER_CONTROL = 8'h0c;
	localparam logic [7:0] RNPC_OFS_UNLOCK_KEY    = 8'h10;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int RNPC_RC_POR       = 0;
	localparam int RNPC_RC_BOR       = 1;
	localparam int RNPC_RC_IDLE      = 2;
	localparam int RNPC_RC_SLEEP     = 3;
	localparam int RNPC_SWR_ARM      = 0;
	localparam int RNPC_NMI_WATCHDOG_SLEEP_TIMEOUT_FLAG     = 16;
	localparam int RNPC_NMI_CF       = 17;
	localparam int RNPC_NMI_GENERAL  = 19;
	localparam int RNPC_NMI_SOFT     = 23;
	localparam int RNPC_NMI_WDT_RUN  = 24;
	localparam int RNPC_PWR_VREG_STB = 0;
	localparam int RNPC_PWR_SLEEP_REGULATOR_LOWPOWER_SELECT    = 1;
	localparam int RNPC_PWR_SOFT_BROWNOUT_ENABLE   = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0]  RNPC_RC_RESET     = 4'h3;
	localparam logic [15:0] RNPC_NMI_RESET_DELAY_COUNT_RESET = 16'h0000;
	localparam logic [2:0]  RNPC_PWR_RESET    = 3'h0;

	// unlock keys: values are arbitrary
	localparam logic [31:0] RNPC_KEY_FIRST  = 32'h5a5a_1234;
	localparam logic [31:0] RNPC_KEY_SECOND = 32'ha5a5_4321;

	// axi responses
	localparam logic [1:0] RNPC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] RNPC_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		RNPC_REG_CAUSE = 3'b000,
		RNPC_REG_SWR   = 3'b001,
		RNPC_REG_NMI   = 3'b010,
		RNPC_REG_PWR   = 3'b011,
		RNPC_REG_KEY   = 3'b100,
		RNPC_REG_NONE  = 3'b111
	} rnpc_reg_sel_t;

	typedef enum logic [1:0] {
		RNPC_LK_LOCKED = 2'b00,
		RNPC_LK_FIRST  = 2'b01,
		RNPC_LK_OPEN   = 2'b10
	} rnpc_lock_state_t;

	// hardware event pulses and configuration levels
	typedef struct packed {
		logic por_event;
		logic bor_event;
		logic wake_from_sleep;
		logic wake_from_idle;
		logic wdt_run_timeout;
		logic wdt_sleep_timeout;
		logic clock_fail_detect;
		logic brownout_config_setting;
		logic retention_config_enable;
	} rnpc_hw_in_t;

	// power-control outputs
	typedef struct packed {
		logic brownout_enable;
		logic regulator_lowpower_sleep;
		logic regulator_active_in_sleep;
	} rnpc_power_out_t;

endpackage

// *** rtl/rnpc_top.sv ***
// reset cause, software reset, nmi control and power control with axi4-lite slave
`timescale 1ns/1ns
`default_nettype none

module rnpc_top (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire rnpc_pkg::rnpc_hw_in_t  hw_in,
	output logic                        nmi_req,
	output logic                        system_reset_req,
	output logic                        fast_osc_switch_req,
	output rnpc_pkg::rnpc_power_out_t   power_out
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic rnpc_pkg::rnpc_reg_sel_t decode(input logic [7:0] addr);
		case (addr)
			rnpc_pkg::RNPC_OFS_RESET_CAUSE:   decode = rnpc_pkg::RNPC_REG_CAUSE;
			rnpc_pkg::RNPC_OFS_SW_RESET:      decode = rnpc_pkg::RNPC_REG_SWR;
			rnpc_pkg::RNPC_OFS_NMI_CONTROL:   decode = rnpc_pkg::RNPC_REG_NMI;
			rnpc_pkg::RNPC_OFS_POWER_CONTROL: decode = rnpc_pkg::RNPC_REG_PWR;
			rnpc_pkg::RNPC_OFS_UNLOCK_KEY:    decode = rnpc_pkg::RNPC_REG_KEY;
			default:                          decode = rnpc_pkg::RNPC_REG_NONE;
		endcase
	endfunction

	// byte-lane merge of write data over the current value
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		merge = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0]                  aw_addr_reg;
	logic                        aw_held_reg;
	logic [31:0]                 w_data_reg;
	logic [3:0]                  w_strb_reg;
	logic                        w_held_reg;
	rnpc_pkg::rnpc_lock_state_t  lock_reg;
	logic [3:0]                  cause_reg;
	logic                        swr_arm_reg;
	logic                        wdt_run_reg;
	logic                        soft_nmi_reg;
	logic                        general_nmi_reg;
	logic                        clock_fail_reg;
	logic                        wdt_sleep_reg;
	logic [15:0]                 nmi_reset_delay_count_reg;
	logic [15:0]                 delay_cnt_reg;
	logic                        delay_run_reg;
	logic                        soft_brownout_enable_reg;
	logic                        sleep_regulator_lowpower_select_reg;
	logic                        vreg_standby_reg;

	logic                        wr_fire;
	logic                        rd_fire;
	rnpc_pkg::rnpc_reg_sel_t     wr_sel;
	rnpc_pkg::rnpc_reg_sel_t     rd_sel;
	logic [31:0]                 wr_val;
	logic                        unlocked;
	logic [31:0]                 nmi_word;
	logic [31:0]                 nmi_new;
	logic                        nmi_wr;
	logic                        wdt_run_start;
	logic [15:0]                 nmi_reload;

	assign wr_fire  = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign rd_fire  = s_axi_arvalid && s_axi_arready;
	assign wr_sel   = decode(aw_addr_reg);
	assign rd_sel   = decode(s_axi_araddr);
	assign unlocked = (lock_reg == rnpc_pkg::RNPC_LK_OPEN);

	always_comb begin
		nmi_word = 32'h0000_0000;
		nmi_word[rnpc_pkg::RNPC_NMI_WDT_RUN] = wdt_run_reg;
		nmi_word[rnpc_pkg::RNPC_NMI_SOFT]    = soft_nmi_reg;
		nmi_word[rnpc_pkg::RNPC_NMI_GENERAL] = general_nmi_reg;
		nmi_word[rnpc_pkg::RNPC_NMI_CF]      = clock_fail_reg;
		nmi_word[rnpc_pkg::RNPC_NMI_WATCHDOG_SLEEP_TIMEOUT_FLAG]    = wdt_sleep_reg;
		nmi_word[15:0]                       = nmi_reset_delay_count_reg;
	end

	// nmi control writes only land while unlocked
	assign nmi_wr  = wr_fire && (wr_sel == rnpc_pkg::RNPC_REG_NMI) && unlocked;
	assign nmi_new = merge(nmi_word, w_data_reg, w_strb_reg);
	assign wr_val  = w_data_reg;
	assign nmi_reload = nmi_wr ? nmi_new[15:0] : nmi_reset_delay_count_reg;

	// a run-mode watchdog nmi begins when the flag goes from clear to set
	assign wdt_run_start = !wdt_run_reg && (hw_in.wdt_run_timeout ||
		(nmi_wr && nmi_new[rnpc_pkg::RNPC_NMI_WDT_RUN]));

	// ------------------------------------------------------------
	// axi write channels
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg   <= 1'b0;
			aw_addr_reg   <= 8'h00;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg   <= 1'b0;
			w_data_reg   <= 32'h0000_0000;
			w_strb_reg   <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= rnpc_pkg::RNPC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_sel == rnpc_pkg::RNPC_REG_NONE) ?
				rnpc_pkg::RNPC_RESP_SLVERR : rnpc_pkg::RNPC_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// axi read channel
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= rnpc_pkg::RNPC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= rnpc_pkg::RNPC_RESP_OKAY;
				case (rd_sel)
					rnpc_pkg::RNPC_REG_CAUSE: s_axi_rdata <= {28'h000_0000, cause_reg};
					rnpc_pkg::RNPC_REG_SWR:   s_axi_rdata <= 32'h0000_0000;
					rnpc_pkg::RNPC_REG_NMI:   s_axi_rdata <= nmi_word;
					rnpc_pkg::RNPC_REG_PWR:   s_axi_rdata <= {29'h0000_0000,
						soft_brownout_enable_reg, sleep_regulator_lowpower_select_reg, vreg_standby_reg};
					rnpc_pkg::RNPC_REG_KEY:   s_axi_rdata <= 32'h0000_0000;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= rnpc_pkg::RNPC_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// unlock sequence
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_reg <= rnpc_pkg::RNPC_LK_LOCKED;
		end else if (wr_fire && wr_sel == rnpc_pkg::RNPC_REG_KEY) begin
			case (lock_reg)
				rnpc_pkg::RNPC_LK_LOCKED, rnpc_pkg::RNPC_LK_OPEN:
					lock_reg <= (wr_val == rnpc_pkg::RNPC_KEY_FIRST) ?
						rnpc_pkg::RNPC_LK_FIRST : rnpc_pkg::RNPC_LK_LOCKED;
				rnpc_pkg::RNPC_LK_FIRST:
					lock_reg <= (wr_val == rnpc_pkg::RNPC_KEY_SECOND) ?
						rnpc_pkg::RNPC_LK_OPEN : rnpc_pkg::RNPC_LK_LOCKED;
				default:
					lock_reg <= rnpc_pkg::RNPC_LK_LOCKED;
			endcase
		end else if (wr_fire && wr_sel != rnpc_pkg::RNPC_REG_NONE
			&& lock_reg == rnpc_pkg::RNPC_LK_FIRST) begin
			lock_reg <= rnpc_pkg::RNPC_LK_LOCKED;
		end
	end

	// ------------------------------------------------------------
	// reset cause flags
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause_reg <= rnpc_pkg::RNPC_RC_RESET;
		end else begin
			if (wr_fire && wr_sel == rnpc_pkg::RNPC_REG_CAUSE && w_strb_reg[0]) begin
				cause_reg <= wr_val[3:0];
			end
			// hardware set wins over a same-cycle software clear
			if (hw_in.wake_from_sleep) begin
				cause_reg[rnpc_pkg::RNPC_RC_SLEEP] <= 1'b1;
			end
			if (hw_in.wake_from_idle || hw_in.wake_from_sleep) begin
				cause_reg[rnpc_pkg::RNPC_RC_IDLE] <= 1'b1;
			end
			if (hw_in.bor_event) begin
				cause_reg[rnpc_pkg::RNPC_RC_BOR] <= 1'b1;
			end
			if (hw_in.por_event) begin
				cause_reg[rnpc_pkg::RNPC_RC_POR] <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// software reset trigger
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			swr_arm_reg <= 1'b0;
		end else if (rd_fire && rd_sel == rnpc_pkg::RNPC_REG_SWR && swr_arm_reg) begin
			swr_arm_reg <= 1'b0;
		end else if (wr_fire && wr_sel == rnpc_pkg::RNPC_REG_SWR && unlocked
			&& w_strb_reg[0] && wr_val[rnpc_pkg::RNPC_SWR_ARM]) begin
			swr_arm_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// nmi flags and reload value
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdt_run_reg     <= 1'b0;
			soft_nmi_reg    <= 1'b0;
			general_nmi_reg <= 1'b0;
			clock_fail_reg  <= 1'b0;
			wdt_sleep_reg   <= 1'b0;
			nmi_reset_delay_count_reg      <= rnpc_pkg::RNPC_NMI_RESET_DELAY_COUNT_RESET;
		end else begin
			if (nmi_wr) begin
				wdt_run_reg     <= nmi_new[rnpc_pkg::RNPC_NMI_WDT_RUN];
				soft_nmi_reg    <= nmi_new[rnpc_pkg::RNPC_NMI_SOFT];
				general_nmi_reg <= nmi_new[rnpc_pkg::RNPC_NMI_GENERAL];
				clock_fail_reg  <= nmi_new[rnpc_pkg::RNPC_NMI_CF];
				wdt_sleep_reg   <= nmi_new[rnpc_pkg::RNPC_NMI_WATCHDOG_SLEEP_TIMEOUT_FLAG];
				nmi_reset_delay_count_reg      <= nmi_new[15:0];
			end
			if (hw_in.wdt_run_timeout) begin
				wdt_run_reg <= 1'b1;
			end
			if (hw_in.clock_fail_detect) begin
				clock_fail_reg <= 1'b1;
			end
			if (hw_in.wdt_sleep_timeout) begin
				wdt_sleep_reg <= 1'b1;
			end
		end
	end

	// any recorded flag holds the nmi; only a detected failure switches the oscillator
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nmi_req             <= 1'b0;
			fast_osc_switch_req <= 1'b0;
		end else begin
			nmi_req <= wdt_run_reg | soft_nmi_reg | general_nmi_reg
				| clock_fail_reg | wdt_sleep_reg;
			fast_osc_switch_req <= hw_in.clock_fail_detect;
		end
	end

	// ------------------------------------------------------------
	// nmi-to-reset delay counter (run-mode watchdog only)
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			delay_cnt_reg <= 16'h0000;
			delay_run_reg <= 1'b0;
		end else if (wdt_run_start && nmi_reload != 16'h0000) begin
			delay_cnt_reg <= nmi_reload;
			delay_run_reg <= 1'b1;
		end else if (delay_run_reg) begin
			if (!wdt_run_reg || delay_cnt_reg == 16'h0001) begin
				delay_run_reg <= 1'b0;
			end
			delay_cnt_reg <= delay_cnt_reg - 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// system reset request
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			system_reset_req <= 1'b0;
		end else begin
			system_reset_req <=
				(rd_fire && rd_sel == rnpc_pkg::RNPC_REG_SWR && swr_arm_reg)
				|| (wdt_run_start && nmi_reload == 16'h0000)
				|| (delay_run_reg && wdt_run_reg && delay_cnt_reg == 16'h0001);
		end
	end

	// ------------------------------------------------------------
	// power control
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vreg_standby_reg         <= rnpc_pkg::RNPC_PWR_RESET[0];
			sleep_regulator_lowpower_select_reg                <= rnpc_pkg::RNPC_PWR_RESET[1];
			soft_brownout_enable_reg <= rnpc_pkg::RNPC_PWR_RESET[2];
		end else if (wr_fire && wr_sel == rnpc_pkg::RNPC_REG_PWR && unlocked
			&& w_strb_reg[0]) begin
			vreg_standby_reg         <= wr_val[rnpc_pkg::RNPC_PWR_VREG_STB];
			soft_brownout_enable_reg <= wr_val[rnpc_pkg::RNPC_PWR_SOFT_BROWNOUT_ENABLE];
			if (wr_val[rnpc_pkg::RNPC_PWR_SLEEP_REGULATOR_LOWPOWER_SELECT]) begin
				sleep_regulator_lowpower_select_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			power_out <= '0;
		end else begin
			power_out.brownout_enable <= soft_brownout_enable_reg
				&& hw_in.brownout_config_setting;
			power_out.regulator_lowpower_sleep <= sleep_regulator_lowpower_select_reg
				&& hw_in.retention_config_enable;
			power_out.regulator_active_in_sleep <= vreg_standby_reg;
		end
	end

endmodule // rnpc_top

`default_nettype wire

// *** dv/rnpc_top_sva.sv ***
// checker: read channel timing, event to nmi latency, power gating
`timescale 1ns/1ns
`default_nettype none
module rnpc_sva (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [7:0]                s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	input  wire logic                      s_axi_arready,
	input  wire logic [31:0]               s_axi_rdata,
	input  wire logic [1:0]                s_axi_rresp,
	input  wire logic                      s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire rnpc_pkg::rnpc_hw_in_t     hw_in,
	input  wire logic                      nmi_req,
	input  wire logic                      system_reset_req,
	input  wire logic                      fast_osc_switch_req,
	input  wire rnpc_pkg::rnpc_power_out_t power_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ------------------------------------------------------------
	// address of the read in flight
	// ------------------------------------------------------------
	logic [7:0] ra_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ra_reg <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			ra_reg <= s_axi_araddr;
	end

	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer not one cycle after address");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped before rready");
	swr_zero_a: assert property (s_axi_rvalid && ra_reg == rnpc_pkg::RNPC_OFS_SW_RESET |-> s_axi_rdata == 32'h0)
		else $error("software reset register read nonzero");
	unmapped_err_a: assert property (s_axi_rvalid && ra_reg >= 8'h14 |-> s_axi_rresp == rnpc_pkg::RNPC_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	nmi_event_a: assert property (hw_in.wdt_run_timeout || hw_in.wdt_sleep_timeout || hw_in.clock_fail_detect |-> ##2 nmi_req)
		else $error("hardware nmi event not raised");
	osc_switch_a: assert property (fast_osc_switch_req == $past(hw_in.clock_fail_detect))
		else $error("oscillator switch not tied to clock failure");
	reset_pulse_a: assert property (system_reset_req |=> !system_reset_req)
		else $error("system reset request longer than one cycle");
	lowpower_gate_a: assert property (!$past(hw_in.retention_config_enable) |-> !power_out.regulator_lowpower_sleep)
		else $error("low power sleep without retention enable");
endmodule // rnpc_sva

bind rnpc_top rnpc_sva chk_i (
	.aclk                (aclk),
	.aresetn             (aresetn),
	.s_axi_araddr        (s_axi_araddr),
	.s_axi_arvalid       (s_axi_arvalid),
	.s_axi_arready       (s_axi_arready),
	.s_axi_rdata         (s_axi_rdata),
	.s_axi_rresp         (s_axi_rresp),
	.s_axi_rvalid        (s_axi_rvalid),
	.s_axi_rready        (s_axi_rready),
	.hw_in               (hw_in),
	.nmi_req             (nmi_req),
	.system_reset_req    (system_reset_req),
	.fast_osc_switch_req (fast_osc_switch_req),
	.power_out           (power_out)
);
`default_nettype wire

// *** dv/test_reset_nmi_power_control.sv ***
// testbench: register table, events, software reset, nmi delay
`timescale 1ns/1ns
`default_nettype none
module test_reset_nmi_power_control;
	typedef struct packed {
		logic        wr;
		logic [7:0]  a;
		logic [31:0] d;
		logic [1:0]  resp;
	} rnpc_row_t;
	localparam logic [7:0] CA = rnpc_pkg::RNPC_OFS_RESET_CAUSE;
	localparam logic [7:0] SW = rnpc_pkg::RNPC_OFS_SW_RESET;
	localparam logic [7:0] NM = rnpc_pkg::RNPC_OFS_NMI_CONTROL;
	localparam logic [7:0] PW = rnpc_pkg::RNPC_OFS_POWER_CONTROL;
	localparam logic [7:0] KY = rnpc_pkg::RNPC_OFS_UNLOCK_KEY;
	localparam logic [1:0] OK = rnpc_pkg::RNPC_RESP_OKAY;
	localparam logic [1:0] ER = rnpc_pkg::RNPC_RESP_SLVERR;

	logic                      aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic                      awready, wready, bvalid, arready, rvalid;
	logic                      nmi_req, system_reset_req, fast_osc_switch_req;
	logic [7:0]                awaddr, araddr;
	logic [31:0]               wdata, rdata, got;
	logic [1:0]                bresp, rresp, resp;
	logic [3:0]                wstrb;
	rnpc_pkg::rnpc_hw_in_t     hw_in;
	rnpc_pkg::rnpc_power_out_t power_out;
	int                        miscompares = 0, checks_done = 0, cyc = 0, pulses = 0;
	int                        last_pulse = 0, p, k;
	int                        evb [4] = '{6, 5, 7, 8};
	logic [31:0]               eve [4] = '{32'hc, 32'h4, 32'h2, 32'h1};
	int                        nb [4] = '{16, 17, 19, 23};
	rnpc_row_t                 rows [10] = '{
		'{1'b0, CA, 32'h3, OK},
		'{1'b1, CA, 32'h0, OK},
		'{1'b0, CA, 32'h0, OK},
		'{1'b1, NM, 32'h0188_0005, OK},
		'{1'b0, NM, 32'h0, OK},
		'{1'b1, PW, 32'h7, OK},
		'{1'b0, PW, 32'h0, OK},
		'{1'b0, SW, 32'h0, OK},
		'{1'b1, 8'h20, 32'h1, ER},
		'{1'b0, 8'h20, 32'h0, ER}
	};

	rnpc_top dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.hw_in(hw_in), .nmi_req(nmi_req), .system_reset_req(system_reset_req),
		.fast_osc_switch_req(fast_osc_switch_req), .power_out(power_out)
	);

	// ------------------------------------------------------------
	// clock, cycle count, reset pulse monitor, hang guard
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (system_reset_req === 1'b1) begin
			pulses <= pulses + 1;
			last_pulse <= cyc;
		end
		if (cyc == 6000) begin
			miscompares++;
			wrap_up;
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			aw_ok |= awvalid & awready;
			w_ok |= wvalid & wready;
			awvalid <= awvalid & !awready;
			wvalid <= wvalid & !wready;
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		// rready held back one cycle so rvalid has to stand
		@(posedge aclk);
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic pulse(input int b);
		hw_in[b] <= 1'b1;
		@(posedge aclk);
		hw_in[b] <= 1'b0;
	endtask

	task automatic unlock;
		wr(KY, rnpc_pkg::RNPC_KEY_FIRST);
		wr(KY, rnpc_pkg::RNPC_KEY_SECOND);
	endtask

	// watchdog nmi by hardware, reload n: one reset n+1 or n+2 cycles on
	task automatic wdt_hw(input logic [15:0] n);
		wr(NM, {16'h0, n});
		p = pulses;
		k = cyc;
		pulse(4);
		repeat (int'(n) + 6) @(posedge aclk);
		chk(pulses - p, 1);
		chk((last_pulse - k - 1 >= n + 1) && (last_pulse - k - 1 <= n + 2), 1);
		wr(NM, 32'h0);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		hw_in = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (rows[i]) begin
			if (rows[i].wr)
				wr(rows[i].a, rows[i].d);
			else
				rd(rows[i].a);
			chk({30'h0, resp}, {30'h0, rows[i].resp});
			if (!rows[i].wr)
				chk(got, rows[i].d);
		end
		foreach (evb[i]) begin
			wr(CA, 32'h0);
			pulse(evb[i]);
			rd(CA);
			chk(got, eve[i]);
			rd(CA);
			chk(got, eve[i]);
		end
		p = pulses;
		wr(SW, 32'h1);
		rd(SW);
		chk(pulses - p, 0);
		unlock;
		wr(SW, 32'h0);
		rd(SW);
		chk(pulses - p, 0);
		wr(SW, 32'h1);
		rd(SW);
		chk(got, 32'h0);
		chk(pulses - p, 1);
		rd(SW);
		chk(pulses - p, 1);
		hw_in.brownout_config_setting <= 1'b1;
		wr(PW, 32'h7);
		repeat (2) @(posedge aclk);
		chk(power_out, 3'b101);
		hw_in.retention_config_enable <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(power_out, 3'b111);
		wr(PW, 32'h0);
		rd(PW);
		chk(got, 32'h2);
		repeat (2) @(posedge aclk);
		chk(power_out, 3'b010);
		p = pulses;
		foreach (nb[i]) begin
			wr(NM, 32'h1 << nb[i]);
			repeat (3) @(posedge aclk);
			chk(nmi_req, 1'b1);
			chk(fast_osc_switch_req, 1'b0);
			rd(NM);
			chk(got, 32'h1 << nb[i]);
			wr(NM, 32'h0);
			repeat (3) @(posedge aclk);
			chk(nmi_req, 1'b0);
		end
		wstrb <= 4'h1;
		wr(NM, 32'hffff_ff07);
		wstrb <= 4'hf;
		rd(NM);
		chk(got, 32'h0000_0007);
		pulse(2);
		@(posedge aclk);
		chk(fast_osc_switch_req, 1'b1);
		pulse(3);
		repeat (4) @(posedge aclk);
		chk(pulses - p, 0);
		wr(NM, 32'h0);
		wdt_hw(16'h0000);
		wdt_hw(16'h0005);
		p = pulses;
		wr(NM, 32'h0100_0003);
		@(posedge aclk);
		chk(pulses - p, 0);
		repeat (12) @(posedge aclk);
		chk(pulses - p, 1);
		wr(NM, 32'h0000_003c);
		p = pulses;
		pulse(4);
		repeat (3) @(posedge aclk);
		wr(NM, 32'h0000_003c);
		repeat (80) @(posedge aclk);
		chk(pulses - p, 0);
		// mid-run reset: cause flags return to reset value, registers lock again
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(CA);
		chk(got, {28'h0, rnpc_pkg::RNPC_RC_RESET});
		wr(PW, 32'h7);
		rd(PW);
		chk(got, 32'h0);
		wrap_up;
	end
endmodule // test_reset_nmi_power_control
`default_nettype wire
